// ==== logic/cec_pkg.sv ====
// Package for the comparator event control block: offsets, fields, types
package cec_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_DIDIS  = 8'h04;
    localparam logic [7:0] OFF_ISTAT  = 8'h08;
    localparam logic [7:0] OFF_IMASK  = 8'h0c;

    // ------------------------------------------------------------------
    // Control/status fields
    // ------------------------------------------------------------------
    localparam int BIT_POWER_OFF  = 7;
    localparam int BIT_BG_SEL     = 6;
    localparam int BIT_RESULT     = 5;
    localparam int BIT_EVT_FLAG   = 4;
    localparam int BIT_IRQ_EN     = 3;
    localparam int BIT_CAP_ROUTE  = 2;
    localparam int BIT_POS_BUFOFF = 0;
    localparam int BIT_NEG_BUFOFF = 1;
    localparam int BIT_IST_EVT    = 0;

    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] DIDIS_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0]
    {
        CEC_MODE_TOGGLE  = 2'b00,
        CEC_MODE_RSVD    = 2'b01,
        CEC_MODE_FALLING = 2'b10,
        CEC_MODE_RISING  = 2'b11
    } cec_mode_t;

    typedef struct packed
    {
        logic      power_off;
        logic      bg_sel;
        logic      irq_en;
        logic      cap_route;
        cec_mode_t mode;
    } cec_ctrl_t;

endpackage : cec_pkg

// ==== logic/cec_top.sv ====
// Comparator event control: AXI4-Lite registers, sync, edge detect, irq
// Operation
// (RULE1) Result high when positive input exceeds negative input, else low.
// (RULE2) Power-off bit 7 switches comparator power off; writable any time.
// (RULE3) Software clears irq enable before changing power-off.
// (RULE4) Bit 6 selects bandgap as positive input, else positive pin.
// (RULE5) Result synchronised into clock domain, readable at bit 5.
// (RULE6) Event flag bit 4 sets on the event the mode selects.
// (RULE7) Interrupt only with flag, enable bit 3 and global enable. The irq output is status AND mask only, without either enable.
// (RULE8) Flag clears on vector acknowledge or software writing one.
// (RULE9) Bit 2 routes result to timer capture front end, else none.
// (RULE10) Software sets timer capture irq enable for capture interrupt.
// (RULE11) Mode bits 1:0: 00 toggle, 01 reserved, 10 fall, 11 rise.
// (RULE12) Software clears irq enable before changing mode field.
// (RULE13) Buffer-off bits turn off pin buffers; pin bit reads zero.
// (RULE14) Software sets buffer-off for analog pins to save power.
// (RULE15) Result bit read-only; edges compare with previous cycle.
`timescale 1ns/1ps
`default_nettype none
module cec_top
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog core
    input  wire logic        positive_input_above,
    input  wire logic        bandgap_above,
    output logic             comparator_power_off,
    output logic             bandgap_reference_select,
    // Pins and CPU
    input  wire logic        positive_pin_raw,
    input  wire logic        negative_pin_raw,
    output logic             positive_pin_in,
    output logic             negative_pin_in,
    output logic             positive_pin_buffer_off,
    output logic             negative_pin_buffer_off,
    input  wire logic        global_irq_enable,
    input  wire logic        irq_vector_ack,
    output logic             comparator_irq,
    output logic             capture_in,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    cec_pkg::cec_ctrl_t ctrl_r;
    logic [1:0]         didis_r;
    logic               flag_r;
    logic               ist_r;
    logic               imask_r;
    logic               sync1_r;
    logic               sync2_r;
    logic               prev_r;
    logic               event_hit;
    logic               raw_cmp;
    logic               wr_fire;
    logic               rd_fire;
    logic               wr_ctrl;
    logic               rd_istat;
    logic [7:0]         wbyte;
    logic               aw_have_r;
    logic               w_have_r;
    logic [7:0]         awaddr_r;
    logic [7:0]         wdata_r;
    logic               wstrb0_r;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == cec_pkg::OFF_CTRL) || (a == cec_pkg::OFF_DIDIS) ||
                 (a == cec_pkg::OFF_ISTAT) || (a == cec_pkg::OFF_IMASK);
    endfunction : mapped

    // ------------------------------------------------------------------
    // Analog selection and synchroniser
    // ------------------------------------------------------------------
    // The analog core reports each input against the negative pin
    always_comb
    begin
        raw_cmp = ctrl_r.bg_sel ? bandgap_above : positive_input_above; // RULE4
        if (ctrl_r.power_off)
            raw_cmp = 1'b0;
    end

    assign comparator_power_off     = ctrl_r.power_off;         // RULE2
    assign bandgap_reference_select = ctrl_r.bg_sel;            // RULE4

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end
        else
        begin
            sync1_r <= raw_cmp;                                  // RULE1
            sync2_r <= sync1_r;                                  // RULE5
            prev_r  <= sync2_r;                                  // RULE15
        end
    end

    // ------------------------------------------------------------------
    // Event detection and flag
    // ------------------------------------------------------------------
    always_comb
    begin
        case (ctrl_r.mode)                                       // RULE11
            cec_pkg::CEC_MODE_TOGGLE:  event_hit = sync2_r ^ prev_r;
            cec_pkg::CEC_MODE_FALLING: event_hit = prev_r & ~sync2_r;
            cec_pkg::CEC_MODE_RISING:  event_hit = sync2_r & ~prev_r;
            default:                   event_hit = 1'b0;
        endcase
    end

    // Set beats clear so an edge during acknowledge is kept
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flag_r <= 1'b0;
        else if (event_hit)
            flag_r <= 1'b1;                                      // RULE6
        else if (irq_vector_ack ||
                 (wr_ctrl && wbyte[cec_pkg::BIT_EVT_FLAG]))
            flag_r <= 1'b0;                                      // RULE8
    end

    assign comparator_irq = flag_r & ctrl_r.irq_en & global_irq_enable; // RULE7
    assign capture_in     = ctrl_r.cap_route & sync2_r;          // RULE9

    // Digital input buffers
    assign positive_pin_buffer_off = didis_r[cec_pkg::BIT_POS_BUFOFF];
    assign negative_pin_buffer_off = didis_r[cec_pkg::BIT_NEG_BUFOFF];
    assign positive_pin_in = positive_pin_raw & ~positive_pin_buffer_off; // RULE13
    assign negative_pin_in = negative_pin_raw & ~negative_pin_buffer_off; // RULE13

    // ------------------------------------------------------------------
    // Sticky status (cleared on read) and mask
    // ------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ist_r <= 1'b0;
        else if (event_hit)
            ist_r <= 1'b1;
        else if (rd_istat)
            ist_r <= 1'b0;
    end

    assign irq = ist_r & imask_r;

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
    assign wr_fire       = aw_have_r && w_have_r && !s_axi_bvalid;
    assign wbyte         = wdata_r;
    assign wr_ctrl       = wr_fire && wstrb0_r &&
                           (awaddr_r == cec_pkg::OFF_CTRL);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 8'h00;
            wstrb0_r  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_r <= 1'b1;
                awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
            end
            else if (wr_fire)
                aw_have_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_r <= 1'b1;
                wdata_r  <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            else if (wr_fire)
                w_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= cec_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_r) ? cec_pkg::RESP_OKAY
                                             : cec_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Control registers; result and flag bits are not stored here
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r  <= cec_pkg::cec_ctrl_t'(6'h00);
            didis_r <= 2'b00;
            imask_r <= 1'b0;
        end
        else if (wr_fire && wstrb0_r)
        begin
            case (awaddr_r)
                cec_pkg::OFF_CTRL:
                begin
                    ctrl_r.power_off <= wbyte[cec_pkg::BIT_POWER_OFF]; // RULE2
                    ctrl_r.bg_sel    <= wbyte[cec_pkg::BIT_BG_SEL];
                    ctrl_r.irq_en    <= wbyte[cec_pkg::BIT_IRQ_EN];    // RULE7
                    ctrl_r.cap_route <= wbyte[cec_pkg::BIT_CAP_ROUTE]; // RULE9
                    ctrl_r.mode      <= cec_pkg::cec_mode_t'(wbyte[1:0]);
                end
                cec_pkg::OFF_DIDIS: didis_r <= wbyte[1:0];             // RULE13
                cec_pkg::OFF_IMASK: imask_r <= wbyte[cec_pkg::BIT_IST_EVT];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;
    assign rd_istat      = rd_fire &&
                           ({s_axi_araddr[7:2], 2'b00} == cec_pkg::OFF_ISTAT);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= cec_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= cec_pkg::RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                cec_pkg::OFF_CTRL:
                    s_axi_rdata <= {24'h00_0000, ctrl_r.power_off,
                                    ctrl_r.bg_sel, sync2_r, flag_r,
                                    ctrl_r.irq_en, ctrl_r.cap_route,
                                    ctrl_r.mode};                // RULE15
                cec_pkg::OFF_DIDIS: s_axi_rdata <= {30'h0, didis_r};
                cec_pkg::OFF_ISTAT: s_axi_rdata <= {31'h0, ist_r};
                cec_pkg::OFF_IMASK: s_axi_rdata <= {31'h0, imask_r};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= cec_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_sync_latency: assert property ( // RULE5
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn, 2) |-> sync2_r == $past(raw_cmp, 2))
        else $error("result not two cycles behind comparator");
    a_rise_sets_flag: assert property ( // RULE6
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_r.mode == cec_pkg::CEC_MODE_RISING && sync2_r && !prev_r)
        |=> flag_r)
        else $error("rising edge did not set flag");
    a_reserved_quiet: assert property ( // RULE11
        @(posedge aclk) disable iff (!aresetn)
        ctrl_r.mode == cec_pkg::CEC_MODE_RSVD |-> !event_hit)
        else $error("reserved mode produced event");
    a_fall_only: assert property ( // RULE11
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_r.mode == cec_pkg::CEC_MODE_FALLING && event_hit)
        |-> (prev_r && !sync2_r))
        else $error("falling mode event without falling edge");
    a_ack_clears: assert property ( // RULE8
        @(posedge aclk) disable iff (!aresetn)
        (irq_vector_ack && !event_hit) |=> !flag_r)
        else $error("acknowledge did not clear flag");
    a_irq_gate: assert property ( // RULE7
        @(posedge aclk) disable iff (!aresetn)
        comparator_irq |-> (flag_r && ctrl_r.irq_en && global_irq_enable))
        else $error("interrupt without all enables");
    a_route_off: assert property ( // RULE9
        @(posedge aclk) disable iff (!aresetn)
        !ctrl_r.cap_route |-> !capture_in)
        else $error("capture driven while route off");
    a_pin_zero: assert property ( // RULE13
        @(posedge aclk) disable iff (!aresetn)
        didis_r[cec_pkg::BIT_POS_BUFOFF] |-> !positive_pin_in)
        else $error("disabled pin reads one");
    a_power_off: assert property ( // RULE2
        @(posedge aclk) disable iff (!aresetn)
        ctrl_r.power_off [*3] |-> !sync2_r)
        else $error("result high while powered off");
    a_bg_used: assert property ( // RULE4
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_r.bg_sel && !ctrl_r.power_off) |-> raw_cmp == bandgap_above)
        else $error("bandgap not selected");
    a_edge_ref: assert property ( // RULE15
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> prev_r == $past(sync2_r))
        else $error("edge reference not one cycle old");
    a_result_ro: assert property ( // RULE1
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn, 3) |-> sync2_r == $past(sync1_r))
        else $error("result altered outside synchroniser");

    c_toggle: cover property (@(posedge aclk) disable iff (!aresetn)
        ctrl_r.mode == cec_pkg::CEC_MODE_TOGGLE && event_hit);
    c_irq: cover property (@(posedge aclk) disable iff (!aresetn)
        comparator_irq ##1 irq_vector_ack);
    c_capture: cover property (@(posedge aclk) disable iff (!aresetn)
        $rose(capture_in));
    c_wr_clear: cover property (@(posedge aclk) disable iff (!aresetn)
        flag_r && wr_ctrl && wbyte[cec_pkg::BIT_EVT_FLAG]);

endmodule : cec_top
`default_nettype wire

// ==== tb/cec_analog_model.sv ====
// Behavioural model of the analog comparator core beside the block
`timescale 1ns/1ps
`default_nettype none
module cec_analog_model
(
    // Clock
    input  wire logic        aclk,
    // Control from the block
    input  wire logic        power_off,
    // Input levels in millivolts
    input  wire logic [11:0] pos_mv,
    input  wire logic [11:0] neg_mv,
    input  wire logic [11:0] bg_mv,
    // Comparator decisions
    output logic             positive_input_above,
    output logic             bandgap_above
);
    // ------------------------------------------------------------------
    // Core decisions
    // ------------------------------------------------------------------
    logic noise_r = 1'b0;

    // An unpowered core gives no valid decision, so it hands out noise
    always @(posedge aclk)
    begin
        noise_r <= ~noise_r;
    end

    always_comb
    begin
        positive_input_above = power_off ? noise_r : (pos_mv > neg_mv);
        bandgap_above        = power_off ? ~noise_r : (bg_mv > neg_mv);
    end
endmodule : cec_analog_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking testbench for the comparator event control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd_data;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, wr_resp, rd_resp;
    logic        pos_above, bg_above, pwr_off, bg_sel;
    logic        pos_raw = 1'b0, neg_raw = 1'b0, gie = 1'b0, vack = 1'b0;
    logic        pos_in, neg_in, pos_off, neg_off, cmp_irq, cap_in, irq;
    logic [11:0] pos_mv = 12'h000, neg_mv = 12'h000, bg_mv = 12'h384;
    int          failures = 0;
    int          num_checks = 0;

    always #10 aclk = ~aclk;

    cec_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .positive_input_above(pos_above),
        .bandgap_above(bg_above), .comparator_power_off(pwr_off),
        .bandgap_reference_select(bg_sel), .positive_pin_raw(pos_raw),
        .negative_pin_raw(neg_raw), .positive_pin_in(pos_in),
        .negative_pin_in(neg_in), .positive_pin_buffer_off(pos_off),
        .negative_pin_buffer_off(neg_off), .global_irq_enable(gie),
        .irq_vector_ack(vack), .comparator_irq(cmp_irq),
        .capture_in(cap_in), .irq(irq));

    cec_analog_model core_u (.aclk(aclk), .power_off(pwr_off),
        .pos_mv(pos_mv), .neg_mv(neg_mv), .bg_mv(bg_mv),
        .positive_input_above(pos_above), .bandgap_above(bg_above));

    // ------------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
            failures++;
        end
    endtask : chk

    // Ready is stable between edges, so it is sampled at the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bit pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (pa || pw)
        begin
            @(negedge aclk);
            ta = pa && awready;
            tw = pw && wready;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do @(negedge aclk); while (!bvalid);
        wr_resp = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr

    // No wait has a limit of its own; the watchdog ends a hung bus
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        rd_data = rdata;
        rd_resp = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask : rd

    // Wait covers the two-stage synchroniser and the flag update
    task automatic setv(input logic [11:0] p, input logic [11:0] n);
        @(posedge aclk);
        pos_mv <= p;
        neg_mv <= n;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
    endtask : setv

    task automatic rdc(input string nm, input logic [7:0] exp);
        rd(cec_pkg::OFF_CTRL);
        chk(nm, rd_data, {24'h0, exp});
    endtask : rdc

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rdc("ctrl reset", cec_pkg::CTRL_RESET);
        rd(cec_pkg::OFF_DIDIS);
        chk("didis reset", rd_data, {24'h0, cec_pkg::DIDIS_RESET});
        rd(cec_pkg::OFF_IMASK);
        chk("imask reset", rd_data, 32'h0);
        rd(8'h10);
        chk("unmapped rresp", 32'(rd_resp), 32'(cec_pkg::RESP_SLVERR));
        chk("unmapped rdata", rd_data, 32'h0);
        wr(8'h14, 8'hff);
        chk("unmapped bresp", 32'(wr_resp), 32'(cec_pkg::RESP_SLVERR));
        $display("test reset done");
    endtask : t_reset

    task automatic t_result();
        setv(12'h258, 12'h190);
        rdc("result high", 8'h30);
        wr(cec_pkg::OFF_CTRL, 8'h10);
        rdc("flag w1c", 8'h20);
        setv(12'h190, 12'h258);
        wr(cec_pkg::OFF_CTRL, 8'h30);
        rdc("result read only", 8'h00);
        $display("test result done");
    endtask : t_result

    task automatic t_modes();
        logic [1:0] m;
        logic       re, fe;
        for (int i = 0; i < 4; i++)
        begin
            m = 2'(i);
            re = (m == 2'b00) || (m == 2'b11);
            fe = (m == 2'b00) || (m == 2'b10);
            wr(cec_pkg::OFF_CTRL, {6'h04, m});
            setv(12'h258, 12'h190);
            rdc("rise event", {3'b001, re, 2'b00, m});
            wr(cec_pkg::OFF_CTRL, {6'h04, m});
            setv(12'h190, 12'h258);
            rdc("fall event", {3'b000, fe, 2'b00, m});
            wr(cec_pkg::OFF_CTRL, {6'h04, m});
        end
        $display("test modes done");
    endtask : t_modes

    task automatic t_irq();
        rd(cec_pkg::OFF_ISTAT);
        chk("status stale", rd_data, 32'h1);
        wr(cec_pkg::OFF_IMASK, 8'h01);
        wr(cec_pkg::OFF_CTRL, 8'h0b);
        setv(12'h258, 12'h190);
        chk("cmp irq no gie", 32'(cmp_irq), 32'h0);
        chk("irq unmasked", 32'(irq), 32'h1);
        @(posedge aclk);
        gie <= 1'b1;
        @(negedge aclk);
        chk("cmp irq taken", 32'(cmp_irq), 32'h1);
        wr(cec_pkg::OFF_CTRL, 8'h03);
        @(negedge aclk);
        chk("cmp irq disabled", 32'(cmp_irq), 32'h0);
        @(posedge aclk);
        vack <= 1'b1;
        @(posedge aclk);
        vack <= 1'b0;
        rdc("flag vector clear", 8'h23);
        rd(cec_pkg::OFF_ISTAT);
        chk("status set", rd_data, 32'h1);
        @(negedge aclk);
        chk("irq after read", 32'(irq), 32'h0);
        wr(cec_pkg::OFF_IMASK, 8'h00);
        setv(12'h190, 12'h258);
        setv(12'h258, 12'h190);
        chk("irq masked", 32'(irq), 32'h0);
        rd(cec_pkg::OFF_ISTAT);
        chk("status masked", rd_data, 32'h1);
        wr(cec_pkg::OFF_CTRL, 8'h10);
        $display("test irq done");
    endtask : t_irq

    task automatic t_route();
        wr(cec_pkg::OFF_CTRL, 8'h04);
        @(negedge aclk);
        chk("capture high", 32'(cap_in), 32'h1);
        setv(12'h190, 12'h258);
        chk("capture low", 32'(cap_in), 32'h0);
        setv(12'h258, 12'h190);
        wr(cec_pkg::OFF_CTRL, 8'h11);
        @(negedge aclk);
        chk("capture off", 32'(cap_in), 32'h0);
        $display("test route done");
    endtask : t_route

    task automatic t_bg_power();
        setv(12'h190, 12'h258);
        wr(cec_pkg::OFF_CTRL, 8'h41);
        chk("bg select", 32'(bg_sel), 32'h1);
        repeat (4) @(posedge aclk);
        rdc("bg above", 8'h61);
        @(posedge aclk);
        bg_mv <= 12'h12c;
        repeat (4) @(posedge aclk);
        rdc("bg below", 8'h41);
        wr(cec_pkg::OFF_CTRL, 8'h01);
        setv(12'h258, 12'h190);
        rdc("pin above", 8'h21);
        wr(cec_pkg::OFF_CTRL, 8'h81);
        chk("power off out", 32'(pwr_off), 32'h1);
        repeat (4) @(posedge aclk);
        rdc("powered off", 8'h81);
        rdc("still off", 8'h81);
        wr(cec_pkg::OFF_CTRL, 8'h01);
        repeat (4) @(posedge aclk);
        rdc("powered on", 8'h21);
        $display("test bandgap and power done");
    endtask : t_bg_power

    task automatic t_didis();
        @(posedge aclk);
        pos_raw <= 1'b1;
        neg_raw <= 1'b1;
        wr(cec_pkg::OFF_DIDIS, 8'h01);
        chk("bufoff pos", {pos_in, neg_in, pos_off, neg_off}, 4'b0110);
        wr(cec_pkg::OFF_DIDIS, 8'h02);
        chk("bufoff neg", {pos_in, neg_in, pos_off, neg_off}, 4'b1001);
        chk("didis bresp", 32'(wr_resp), 32'(cec_pkg::RESP_OKAY));
        rd(cec_pkg::OFF_DIDIS);
        chk("didis read", rd_data, 32'h2);
        wstrb <= 4'he;
        wr(cec_pkg::OFF_DIDIS, 8'h01);
        wstrb <= 4'hf;
        rd(cec_pkg::OFF_DIDIS);
        chk("didis no strobe", rd_data, 32'h2);
        chk("no strobe bresp", 32'(wr_resp), 32'(cec_pkg::RESP_OKAY));
        wr(cec_pkg::OFF_DIDIS, 8'h00);
        chk("bufon", {pos_in, neg_in, pos_off, neg_off}, 4'b1100);
        $display("test input disable done");
    endtask : t_didis

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_result();
        t_modes();
        t_irq();
        t_route();
        t_bg_power();
        t_didis();
        summarize();
    end

    initial
    begin
        repeat (6000) @(posedge aclk);
        failures++;
        summarize();
    end
endmodule : tb
`default_nettype wire
